// ### core/rpm_top.sv
// Register file and top level of the receive pattern compare block.
// Assumes an AXI4-Lite master on clock and a received byte stream on the
// same clock, with rx_sof on the first byte after the frame delimiter.
`default_nettype none
module rpm_top (
  // Clock and reset
  input  wire logic                       clock,
  input  wire logic                       rst,
  // AXI4-Lite write
  input  wire logic [rpm_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [rpm_pkg::AXI_DW-1:0] s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // AXI4-Lite read
  input  wire logic [rpm_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [rpm_pkg::AXI_DW-1:0]      s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // Received byte stream
  input  wire logic                       rx_valid,
  input  wire logic [7:0]                 rx_data,
  input  wire logic                       rx_sof,
  input  wire logic                       rx_eop,
  // Compare result
  output logic                            pattern_match,
  output logic                            compare_done
);
  import rpm_pkg::*;

  logic [REG_W-1:0]          pattern_word [N_WORD];
  logic [REG_W-1:0]          byte_mask    [N_MASK];
  logic [START_W-1:0]        compare_start_offset;
  logic                      compare_en;
  logic                      match_seen;
  logic                      last_result;
  logic                      wr_en;
  logic [IDX_W-1:0]          wr_idx;
  logic [REG_W-1:0]          wr_data;
  logic [1:0]                wr_strb;
  logic                      wr_ok;
  logic [IDX_W-1:0]          rd_idx;
  logic [REG_W-1:0]          rd_word;
  logic                      rd_ok;
  logic [8*N_BYTE-1:0]       pattern_flat;
  logic [N_BYTE-1:0]         mask_flat;
  logic                      cmp_match;
  logic                      cmp_done;
  logic                      cmp_busy;

  // RULE_11 contiguous pattern words
  function automatic logic is_pat(input logic [IDX_W-1:0] idx);
    is_pat = (idx >= IDX_PAT_BASE) &&
             (idx <= IDX_PAT_62_63);
  endfunction

  function automatic logic is_mask(input logic [IDX_W-1:0] idx);
    is_mask = (idx >= IDX_MASK_A) && (idx <= IDX_MASK_D);
  endfunction

  function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
    is_mapped = is_pat(idx) || is_mask(idx) ||
                (idx == IDX_START) || (idx == IDX_CTRL);
  endfunction

  // Byte lane merge, so a single-lane store keeps the other byte
  function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old_v,
                                             input logic [REG_W-1:0] new_v,
                                             input logic [1:0]       strb);
    merge = {strb[1] ? new_v[15:8] : old_v[15:8],
             strb[0] ? new_v[7:0]  : old_v[7:0]};
  endfunction

  rpm_axil_slave u_bus (
    .clock         (clock),
    .rst           (rst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_idx        (wr_idx),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_ok         (wr_ok),
    .rd_idx        (rd_idx),
    .rd_word       (rd_word),
    .rd_ok         (rd_ok)
  );

  assign wr_ok = is_mapped(wr_idx);
  assign rd_ok = is_mapped(rd_idx);

  // RULE_01 pattern word storage
  // RULE_02 final pattern word
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int n = 0; n < N_WORD; n++) begin
        pattern_word[n] <= PAT_RST;
      end
    end else if (wr_en && is_pat(wr_idx)) begin
      pattern_word[5'(wr_idx - IDX_PAT_BASE)] <=
        merge(pattern_word[5'(wr_idx - IDX_PAT_BASE)], wr_data, wr_strb);
    end
  end

  // RULE_04 mask a, RULE_05 mask b, RULE_06 mask c, RULE_07 mask d
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int m = 0; m < N_MASK; m++) begin
        byte_mask[m] <= MASK_RST;
      end
    end else if (wr_en && is_mask(wr_idx)) begin
      byte_mask[2'(wr_idx - IDX_MASK_A)] <=
        merge(byte_mask[2'(wr_idx - IDX_MASK_A)], wr_data, wr_strb);
    end
  end

  // RULE_10 upper start bits never stored
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      compare_start_offset <= START_RST;
    end else if (wr_en && wr_idx == IDX_START && wr_strb[0]) begin
      compare_start_offset <= wr_data[START_W-1:0];
    end
  end

  // Control and status; a new match wins over a clear in the same cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      compare_en  <= EN_RST;
      match_seen  <= 1'b0;
      last_result <= 1'b0;
    end else begin
      if (wr_en && wr_idx == IDX_CTRL && wr_strb[0]) begin
        compare_en <= wr_data[CTRL_EN_BIT];
      end
      if (cmp_match) begin
        match_seen <= 1'b1;
      end else if (wr_en && wr_idx == IDX_CTRL && wr_strb[0] &&
                   wr_data[CTRL_MATCH_BIT]) begin
        match_seen <= 1'b0;
      end
      if (cmp_done) begin
        last_result <= cmp_match;
      end
    end
  end

  // Read mux; unmapped indices read zero and get an error answer
  always_comb begin
    rd_word = 16'h0000;
    if (is_pat(rd_idx)) begin
      rd_word = pattern_word[5'(rd_idx - IDX_PAT_BASE)];
    end else if (is_mask(rd_idx)) begin
      rd_word = byte_mask[2'(rd_idx - IDX_MASK_A)];
    end else if (rd_idx == IDX_START) begin
      rd_word = {10'h000, compare_start_offset};
    end else if (rd_idx == IDX_CTRL) begin
      rd_word[CTRL_EN_BIT]    = compare_en;
      rd_word[CTRL_MATCH_BIT] = match_seen;
      rd_word[CTRL_BUSY_BIT]  = cmp_busy;
      rd_word[CTRL_LAST_BIT]  = last_result;
    end
  end

  // RULE_03 one mask bit per byte
  // RULE_12 bit order within words
  always_comb begin
    for (int n = 0; n < N_WORD; n++) begin
      pattern_flat[16*n +: 16] = pattern_word[n];
    end
    for (int m = 0; m < N_MASK; m++) begin
      mask_flat[16*m +: 16] = byte_mask[m];
    end
  end

  rpm_compare u_cmp (
    .clock    (clock),
    .rst      (rst),
    .enable   (compare_en),
    .start_pt (compare_start_offset),
    .pattern  (pattern_flat),
    .mask     (mask_flat),
    .rx_valid (rx_valid),
    .rx_data  (rx_data),
    .rx_sof   (rx_sof),
    .rx_eop   (rx_eop),
    .match    (cmp_match),
    .done     (cmp_done),
    .busy     (cmp_busy)
  );

  assign pattern_match = cmp_match;
  assign compare_done  = cmp_done;

  // Checks on register storage and compare result
  property p_pat_60_61;
    @(posedge clock) disable iff (rst)
    wr_en && wr_idx == IDX_PAT_60_61 && wr_strb == 2'h3
      |=> pattern_word[30] == $past(wr_data) && pattern_flat[495:480] ==
          $past(wr_data);
  endproperty
  a_pat_60_61: assert property (p_pat_60_61) // RULE_01
    else $error("pattern word for bytes 60 and 61 not stored");

  property p_pat_62_63;
    @(posedge clock) disable iff (rst)
    wr_en && wr_idx == IDX_PAT_62_63 && wr_strb == 2'h3
      |=> pattern_flat[511:496] == $past(wr_data);
  endproperty
  a_pat_62_63: assert property (p_pat_62_63) // RULE_02
    else $error("pattern byte 63 not in upper lane");

  property p_mask_rst;
    @(posedge clock)
    $fell(rst) |-> mask_flat == 64'h0000000000000000;
  endproperty
  a_mask_rst: assert property (p_mask_rst) // RULE_04
    else $error("byte masks not zero after reset");

  property p_mask_b;
    @(posedge clock) disable iff (rst)
    wr_en && wr_idx == IDX_MASK_B && wr_strb == 2'h3
      |=> mask_flat[31:16] == $past(wr_data) && $stable(mask_flat[15:0]);
  endproperty
  a_mask_b: assert property (p_mask_b) // RULE_05
    else $error("mask word b not stored in bytes 16 to 31");

  property p_mask_d;
    @(posedge clock) disable iff (rst)
    wr_en && wr_idx == IDX_MASK_D && wr_strb == 2'h3
      |=> mask_flat[63:48] == $past(wr_data) && $stable(mask_flat[47:32]);
  endproperty
  a_mask_d: assert property (p_mask_d) // RULE_07
    else $error("mask word d not stored in bytes 48 to 63");

  property p_start_wr;
    @(posedge clock) disable iff (rst)
    wr_en && wr_idx == IDX_START && wr_strb[0]
      |=> {10'h000, compare_start_offset} == ($past(wr_data) & 16'h003F);
  endproperty
  a_start_wr: assert property (p_start_wr) // RULE_09
    else $error("start point not taken from bits 5:0");

  property p_start_upper;
    @(posedge clock) disable iff (rst)
    s_axi_arvalid && s_axi_arready && rd_idx == IDX_START
      |=> s_axi_rvalid && s_axi_rdata[15:6] == 10'h000;
  endproperty
  a_start_upper: assert property (p_start_upper) // RULE_10
    else $error("start register upper bits not zero");

  property p_masked_pass;
    @(posedge clock) disable iff (rst)
    u_cmp.last && mask_flat[63] && !u_cmp.bad_acc |=> cmp_match;
  endproperty
  a_masked_pass: assert property (p_masked_pass) // RULE_08
    else $error("masked final byte blocked the match");

  property p_match_cause;
    @(posedge clock) disable iff (rst)
    cmp_match |-> cmp_done && $past(u_cmp.last) &&
                  !($past(u_cmp.in_win) && !$past(u_cmp.byte_ok));
  endproperty
  a_match_cause: assert property (p_match_cause) // RULE_13
    else $error("match without a clean final byte");

  property p_mismatch_kills;
    @(posedge clock) disable iff (rst)
    u_cmp.in_win && !u_cmp.byte_ok && u_cmp.pos != 7'h3F
      |=> !cmp_match [*2];
  endproperty
  a_mismatch_kills: assert property (p_mismatch_kills) // RULE_13
    else $error("match after an unmasked mismatch");

  property p_seen_set;
    @(posedge clock) disable iff (rst)
    cmp_match |=> match_seen;
  endproperty
  a_seen_set: assert property (p_seen_set)
    else $error("match flag lost against a clear");

  // Main scenarios
  c_match: cover property (@(posedge clock) disable iff (rst) cmp_match);
  c_miss: cover property (@(posedge clock) disable iff (rst)
    cmp_done && !cmp_match);
  c_late_start: cover property (@(posedge clock) disable iff (rst)
    cmp_match && compare_start_offset == 6'h3F);
  c_masked: cover property (@(posedge clock) disable iff (rst)
    u_cmp.in_win && mask_flat[u_cmp.pos[5:0]] &&
    (pattern_flat[8*u_cmp.pos[5:0] +: 8] != rx_data));
endmodule // rpm_top
`default_nettype wire

// ### include/rpm_pkg.sv
// Notes on behaviour
// RULE_01 - Word at index 0x15A holds pattern bytes 60 and 61 for compare.
// RULE_02 - Word at index 0x15B holds pattern bytes 62 and 63, the last two.
// RULE_03 - Each of the 64 pattern bytes has its own independent mask bit.
// RULE_04 - Mask word at index 0x15C covers bytes 0 to 15, resets to zero.
// RULE_05 - Mask word at index 0x15D covers bytes 16 to 31, resets to zero.
// RULE_06 - Mask word at index 0x15E covers bytes 32 to 47, resets to zero.
// RULE_07 - Mask word at index 0x15F covers bytes 48 to 63, resets to zero.
// RULE_08 - Mask bit one drops its byte from the compare; zero keeps it.
// RULE_09 - Start field bits 5:0 at 0x161 picks first compared byte after SFD.
// RULE_10 - Start register bits 15:6 ignore writes and read back zero.
// RULE_11 - Lower words each hold two consecutive bytes at successive indices.
// RULE_12 - Mask bit i is byte i of range; lower byte sits in bits 7:0.
// RULE_13 - Match only if all unmasked bytes equal received bytes from start.
//
// Package of the receive pattern compare block: register indices, widths,
// reset values and bus answer codes. Assumes a 32-bit AXI4-Lite master and
// a byte stream on the same clock as the register file.
package rpm_pkg;
  // Bus geometry; byte address is four times the register index
  localparam int unsigned AXI_AW   = 12;
  localparam int unsigned AXI_DW   = 32;
  localparam int unsigned IDX_W    = 10;
  localparam int unsigned REG_W    = 16;
  // Pattern geometry
  localparam int unsigned N_WORD   = 32;
  localparam int unsigned N_BYTE   = 64;
  localparam int unsigned N_MASK   = 4;
  localparam int unsigned START_W  = 6;
  localparam int unsigned CNT_W    = 7;
  // Register indices
  localparam logic [9:0] IDX_PAT_BASE  = 10'h13C;
  localparam logic [9:0] IDX_PAT_60_61 = 10'h15A;
  localparam logic [9:0] IDX_PAT_62_63 = 10'h15B;
  localparam logic [9:0] IDX_MASK_A    = 10'h15C;
  localparam logic [9:0] IDX_MASK_B    = 10'h15D;
  localparam logic [9:0] IDX_MASK_C    = 10'h15E;
  localparam logic [9:0] IDX_MASK_D    = 10'h15F;
  localparam logic [9:0] IDX_START     = 10'h161;
  localparam logic [9:0] IDX_CTRL      = 10'h162;
  // Control and status bit positions
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_MATCH_BIT = 1;
  localparam int unsigned CTRL_BUSY_BIT  = 2;
  localparam int unsigned CTRL_LAST_BIT  = 3;
  // Reset values
  localparam logic [15:0] PAT_RST   = 16'h0000;
  localparam logic [15:0] MASK_RST  = 16'h0000;
  localparam logic [5:0]  START_RST = 6'h00;
  localparam logic        EN_RST    = 1'h0;
  // Bus answers
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // Comparator states
  typedef enum logic [0:0] {
    RPM_IDLE   = 1'b0,
    RPM_ACTIVE = 1'b1
  } rpm_state_e;
endpackage // rpm_pkg

// ### core/rpm_axil_slave.sv
// AXI4-Lite slave front end for the pattern compare registers.
// Assumes the register file answers reads and writes combinationally.
`default_nettype none
module rpm_axil_slave (
  // Clock and reset
  input  wire logic                      clock,
  input  wire logic                      rst,
  // Write address, data and response
  input  wire logic [rpm_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [rpm_pkg::AXI_DW-1:0] s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // Read channels
  input  wire logic [rpm_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [rpm_pkg::AXI_DW-1:0]     s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // Register file side
  output logic                           wr_en,
  output logic [rpm_pkg::IDX_W-1:0]      wr_idx,
  output logic [rpm_pkg::REG_W-1:0]      wr_data,
  output logic [1:0]                     wr_strb,
  input  wire logic                      wr_ok,
  output logic [rpm_pkg::IDX_W-1:0]      rd_idx,
  input  wire logic [rpm_pkg::REG_W-1:0] rd_word,
  input  wire logic                      rd_ok
);
  import rpm_pkg::*;

  logic                  aw_held;
  logic                  w_held;
  logic [IDX_W-1:0]      aw_idx;
  logic [REG_W-1:0]      w_data;
  logic [1:0]            w_strb;

  // Channels taken in either order; blocked while a response waits
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_en   = aw_held && w_held && !s_axi_bvalid;
  assign wr_idx  = aw_idx;
  assign wr_data = w_data;
  assign wr_strb = w_strb;
  assign rd_idx  = s_axi_araddr[AXI_AW-1:2];

  // Write capture and response; upper data lanes are dropped
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_idx       <= '0;
      w_data       <= '0;
      w_strb       <= 2'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_idx  <= s_axi_awaddr[AXI_AW-1:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata[REG_W-1:0];
        w_strb <= s_axi_wstrb[1:0];
      end
      if (wr_en) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {16'h0000, rd_ok ? rd_word : 16'h0000};
      s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // rpm_axil_slave
`default_nettype wire

// ### core/rpm_compare.sv
// Byte stream comparator against the 64-byte pattern and its masks.
// Assumes the stream is on the register clock; rx_sof marks byte one
// after the frame delimiter.
`default_nettype none
module rpm_compare (
  // Clock and reset
  input  wire logic                         clock,
  input  wire logic                         rst,
  // Configuration
  input  wire logic                         enable,
  input  wire logic [rpm_pkg::START_W-1:0]  start_pt,
  input  wire logic [8*rpm_pkg::N_BYTE-1:0] pattern,
  input  wire logic [rpm_pkg::N_BYTE-1:0]   mask,
  // Received stream
  input  wire logic                         rx_valid,
  input  wire logic [7:0]                   rx_data,
  input  wire logic                         rx_sof,
  input  wire logic                         rx_eop,
  // Result
  output logic                              match,
  output logic                              done,
  output logic                              busy
);
  import rpm_pkg::*;

  rpm_state_e            state;
  logic [CNT_W-1:0]      cnt;
  logic                  bad_acc;
  logic                  in_frame;
  logic [CNT_W-1:0]      cur_idx;
  logic [CNT_W-1:0]      pos;
  logic                  in_win;
  logic                  byte_ok;
  logic                  bad_eff;
  logic                  last;

  // RULE_12 lower byte first
  function automatic logic [7:0] pat_byte(input logic [CNT_W-1:0] p);
    pat_byte = pattern[8*p[5:0] +: 8];
  endfunction

  assign in_frame = enable && rx_valid && (rx_sof || state == RPM_ACTIVE);
  assign cur_idx  = rx_sof ? '0 : cnt;
  // RULE_09 window from start point
  assign pos      = cur_idx - {1'b0, start_pt};
  assign in_win   = in_frame && (cur_idx >= {1'b0, start_pt}) && !pos[6];
  // RULE_08 masked byte always passes
  assign byte_ok  = mask[pos[5:0]] || (pat_byte(pos) == rx_data);
  assign bad_eff  = (in_win && !byte_ok) ||
                    (bad_acc && !(in_win && pos == '0));
  assign last     = in_win && (pos == 7'h3F);

  // Frame tracking; byte count saturates past the window
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= RPM_IDLE;
      cnt   <= '0;
    end else if (!enable) begin
      state <= RPM_IDLE;
    end else if (in_frame) begin
      state <= (rx_eop || last) ? RPM_IDLE : RPM_ACTIVE;
      cnt   <= (cur_idx == 7'h7F) ? cur_idx : cur_idx + 7'h01;
    end
  end

  // RULE_13 accumulate mismatches
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bad_acc <= 1'b0;
      match   <= 1'b0;
      done    <= 1'b0;
    end else begin
      if (in_win) begin
        bad_acc <= bad_eff;
      end
      match <= last && !bad_eff;
      done  <= last || (in_frame && rx_eop);
    end
  end

  assign busy = (state == RPM_ACTIVE);
endmodule // rpm_compare
`default_nettype wire

// ### testbench/rpm_top_tb_top.sv
// Self-checking bench for the receive pattern compare block.
// Assumes rpm_top with AXI4-Lite on clock and a same-clock byte stream.
`default_nettype none
module rpm_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rpm_pkg::*;
  // Bench-driven inputs, all valued at time zero
  logic        clock = 1'b0, rst = 1'b1;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0]  s_axi_wstrb = '0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        rx_valid = 0, rx_sof = 0, rx_eop = 0;
  logic [7:0]  rx_data = '0;
  // Design outputs and captured answers
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, pattern_match, compare_done, m, d;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rd;
  int          errors = 0, cmp_count = 0, cyc = 0;
  always #25 clock = ~clock;
  rpm_top rpm_top_inst (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .rx_valid, .rx_data, .rx_sof, .rx_eop, .pattern_match, .compare_done);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Pattern byte p; consecutive bytes always differ
  function automatic logic [7:0] pb(input int p);
    return 8'(p * 37 + 5);
  endfunction
  // Write one word; ready sampled mid-cycle, released after the taking edge
  task automatic wr(input logic [9:0] i, input logic [31:0] v);
    logic ta, tw, pa, pw;
    pa = 1;
    pw = 1;
    @(posedge clock);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (pa || pw) begin
      @(negedge clock);
      ta = s_axi_awready & pa;
      tw = s_axi_wready & pw;
      @(posedge clock);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      pa = pa & ~ta;
      pw = pw & ~tw;
    end
    do begin
      @(negedge clock);
      ta = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge clock);
    end while (ta !== 1'b1);
    s_axi_bready <= 0;
  endtask
  // Read one word into rd and rs
  task automatic rdr(input logic [9:0] i);
    logic t;
    @(posedge clock);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(negedge clock);
      t = s_axi_arready;
      @(posedge clock);
    end while (t !== 1'b1);
    s_axi_arvalid <= 0;
    do begin
      @(negedge clock);
      t = s_axi_rvalid;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge clock);
    end while (t !== 1'b1);
    s_axi_rready <= 0;
  endtask
  // Frame with pattern at byte st, byte bad corrupted; eop only if short
  task automatic frame(input int st, input int bad, input int len);
    for (int k = 0; k < len; k++) begin
      @(posedge clock);
      rx_valid <= 1;
      rx_sof <= (k == 0);
      rx_eop <= (k == len - 1 && len < st + 64);
      rx_data <= (k < st) ? 8'hC3 :
                 pb(k - st) ^ ((k - st == bad) ? 8'h10 : 8'h00);
    end
    @(posedge clock);
    rx_valid <= 0;
    rx_sof <= 0;
    rx_eop <= 0;
    d = 0;
    m = 0;
    for (int n = 0; n < 4 && d !== 1'b1; n++) begin
      @(negedge clock);
      d = compare_done;
      m = pattern_match;
    end
  endtask
  // Cut a hang short; the run needs about 800 cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      print_verdict;
    end
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge clock);
    rst <= 0;
    for (int i = 0; i < 4; i++) begin
      rdr(10'(IDX_MASK_A + i));
      chk(rd, 32'h0);
    end
    for (int w = 0; w < N_WORD; w++)
      wr(10'(IDX_PAT_BASE + w), {16'h0, pb(2 * w + 1), pb(2 * w)});
    chk({30'h0, rs}, {30'h0, RESP_OKAY});
    rdr(IDX_PAT_60_61);
    chk(rd, {16'h0, pb(61), pb(60)});
    rdr(IDX_PAT_62_63);
    chk(rd, {16'h0, pb(63), pb(62)});
    for (int i = 0; i < 4; i++) begin
      wr(10'(IDX_MASK_A + i), 32'hFFFF_0000 | (32'h1111 << i));
      rdr(10'(IDX_MASK_A + i));
      chk(rd, 32'h1111 << i);
      wr(10'(IDX_MASK_A + i), 32'h0);
    end
    // Reserved start bits must not stick
    wr(IDX_START, 32'hFFC0);
    rdr(IDX_START);
    chk(rd, 32'h0);
    wr(10'h160, 32'h1234);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    rdr(10'h160);
    chk(rd, 32'h0);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    wr(IDX_CTRL, 32'h1);
    wr(IDX_START, 32'h0);
    frame(0, -1, 64);
    chk(32'(m), 32'h1);
    // Enable, sticky match and last result set, not busy
    rdr(IDX_CTRL);
    chk(rd, 32'hB);
    frame(0, 63, 64);
    chk(32'({m, d}), 32'h1);
    wr(IDX_MASK_D, 32'h8000);
    frame(0, 63, 64);
    chk(32'(m), 32'h1);
    frame(0, 60, 64);
    chk(32'(m), 32'h0);
    wr(IDX_MASK_D, 32'h0);
    // Start point honoured at 2 and at the top end of its range, 63
    for (int s = 2; s < 64; s += 61) begin
      wr(IDX_START, s);
      frame(s, -1, s + 64);
      chk(32'(m), 32'h1);
    end
    wr(IDX_START, 32'h2);
    frame(3, -1, 66);
    chk(32'({m, d}), 32'h1);
    // Frame ending early gives done without match
    frame(2, -1, 10);
    chk(32'({m, d}), 32'h1);
    print_verdict;
  end
endmodule // rpm_top_tb_top
`default_nettype wire
